// ===== bench/test_cpu_dec_core.sv
// self-checking bench for the inc/dec-skip, branch, or, pointer and move executor
module test_cpu_dec_core;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // types, signals, reference state
    // ------------------------------------------------------------
    typedef struct packed {
        cpu_dec_pkg::file_wr_t wr;
        cpu_dec_pkg::core_state_t st;
        logic [20:0] pc;
        logic [35:0] ptrs;
        logic disc;
        logic ill;
    } note_t;
    logic i_clk, i_rst, i_instr_valid;
    logic [15:0] i_instr;
    logic [7:0] i_file_rdata;
    logic [3:0] i_bank_select_reg;
    logic [11:0] o_file_raddr;
    cpu_dec_pkg::file_wr_t o_file_wr;
    cpu_dec_pkg::core_state_t o_state;
    logic [20:0] o_pc;
    logic [11:0] o_indirect_pointer_reg [cpu_dec_pkg::NUM_PTRS];
    logic o_discard, o_illegal;
    logic [7:0] mem [4096];           // register file stand-in
    note_t q [$];                      // expected results, oldest first
    int err_count = 0;
    int n_compared = 0;
    logic [31:0] rnd = 32'h6cbe;
    logic [7:0] m_acc = 8'h00, br_lo = 8'h00;
    logic [4:0] m_flags = 5'h00;
    logic [20:0] m_pc = 21'h000000;
    logic [11:0] m_ptr [3] = '{12'h000, 12'h000, 12'h000};
    logic skip_q = 1'b0, br_q = 1'b0, ptr_q = 1'b0;
    logic [1:0] ptr_sel = 2'h0;
    logic [5:0] ops6 [7] = '{cpu_dec_pkg::OP6_DEC_SKIP_Z, cpu_dec_pkg::OP6_DEC_SKIP_NZ,
        cpu_dec_pkg::OP6_INC_FILE, cpu_dec_pkg::OP6_INC_SKIP_Z, cpu_dec_pkg::OP6_INC_SKIP_NZ,
        cpu_dec_pkg::OP6_OR_FILE, cpu_dec_pkg::OP6_MOVE_FILE};
    logic [7:0] pokes [4] = '{8'h00, 8'h01, 8'hff, 8'h7f};   // zero/carry/overflow edges

    cpu_dec_core cpu_dec_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
        .i_instr(i_instr), .i_file_rdata(i_file_rdata), .i_bank_select_reg(i_bank_select_reg),
        .o_file_raddr(o_file_raddr), .o_file_wr(o_file_wr), .o_state(o_state), .o_pc(o_pc),
        .o_indirect_pointer_reg(o_indirect_pointer_reg), .o_discard(o_discard),
        .o_illegal(o_illegal));

    // combinational file read, registered file write
    assign i_file_rdata = mem[o_file_raddr];
    always @(posedge i_clk)
    begin
        if (o_file_wr.en)
            mem[o_file_wr.addr] <= o_file_wr.data;
    end

    // 200 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] load_pointer_literal_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // driver: present one word, note what the core must do with it
    // ------------------------------------------------------------
    task automatic issue(input logic [15:0] w, input logic [3:0] bank_select_reg, input logic [7:0] pv,
                         input logic pk);
        note_t n;
        logic [11:0] ad;
        logic [7:0] v, r;
        logic sk, nz;
        @(posedge i_clk);
        i_instr <= w;
        i_instr_valid <= 1'b1;
        i_bank_select_reg <= bank_select_reg;
        #1;
        // access bit zero forces the fixed bank
        ad = w[8] ? {bank_select_reg, w[7:0]} : {(w[7:0] < cpu_dec_pkg::ACCESS_SPLIT) ?
            cpu_dec_pkg::ACCESS_BANK : cpu_dec_pkg::ACCESS_HIGH_BANK, w[7:0]};
        if (pk)
            mem[ad] = pv;
        v = mem[ad];
        n = '0;
        sk = 1'b0;
        nz = 1'b0;
        r = 8'h00;
        if (br_q)
        begin
            // second word loads pc bits 20:1, cycle idles
            m_pc = {w[11:0], br_lo, 1'b0};
            n.disc = 1'b1;
            br_q = 1'b0;
        end
        else
        begin
            m_pc = m_pc + 21'h2;
            if (skip_q)
            begin
                // discarded word, two-word form costs one more
                n.disc = 1'b1;
                skip_q = (w[15:8] == cpu_dec_pkg::OP8_BRANCH) ||
                         (w[15:6] == cpu_dec_pkg::OP10_LOAD_PTR);
            end
            else if (ptr_q)
            begin
                m_ptr[ptr_sel][7:0] = w[7:0];
                ptr_q = 1'b0;
            end
            else if (w[15:8] == cpu_dec_pkg::OP8_BRANCH)
            begin
                br_lo = w[7:0];
                br_q = 1'b1;
            end
            else if (w[15:6] == cpu_dec_pkg::OP10_LOAD_PTR)
            begin
                ptr_sel = w[5:4];
                m_ptr[ptr_sel][11:8] = w[3:0];
                ptr_q = 1'b1;
            end
            else if (w[15:8] == cpu_dec_pkg::OP8_OR_LIT)
            begin
                m_acc = m_acc | w[7:0];
                r = m_acc;
                nz = 1'b1;
            end
            else
            begin
                check(64'(o_file_raddr), 64'(ad));
                case (w[15:10])
                    cpu_dec_pkg::OP6_DEC_SKIP_Z: begin r = v - 8'h01; sk = (r == 8'h00); end
                    cpu_dec_pkg::OP6_DEC_SKIP_NZ: begin r = v - 8'h01; sk = (r != 8'h00); end
                    cpu_dec_pkg::OP6_INC_SKIP_Z: begin r = v + 8'h01; sk = (r == 8'h00); end
                    cpu_dec_pkg::OP6_INC_SKIP_NZ: begin r = v + 8'h01; sk = (r != 8'h00); end
                    cpu_dec_pkg::OP6_INC_FILE:
                    begin
                        // plain increment sets all five flags
                        r = v + 8'h01;
                        m_flags[cpu_dec_pkg::FLAG_C] = (v == 8'hff);
                        m_flags[cpu_dec_pkg::FLAG_DC] = (v[3:0] == 4'hf);
                        m_flags[cpu_dec_pkg::FLAG_OV] = (v == 8'h7f);
                        nz = 1'b1;
                    end
                    cpu_dec_pkg::OP6_OR_FILE: begin r = m_acc | v; nz = 1'b1; end
                    cpu_dec_pkg::OP6_MOVE_FILE: begin r = v; nz = 1'b1; end
                    default: n.ill = 1'b1;
                endcase
                // dest bit picks file or acc
                if (!n.ill && w[cpu_dec_pkg::BIT_DEST])
                    n.wr = '{addr: ad, data: r, en: 1'b1};
                else if (!n.ill)
                    m_acc = r;
                skip_q = sk;
            end
            if (nz)
            begin
                m_flags[cpu_dec_pkg::FLAG_N] = r[7];
                m_flags[cpu_dec_pkg::FLAG_Z] = (r == 8'h00);
            end
        end
        n.st = '{flags: m_flags, acc: m_acc};
        n.pc = m_pc;
        n.ptrs = {m_ptr[2], m_ptr[1], m_ptr[0]};
        q.push_back(n);
    endtask

    // ------------------------------------------------------------
    // monitor: one note per taken word, quiet pulses otherwise
    // ------------------------------------------------------------
    always @(posedge i_clk)
    begin : watch
        logic taken;
        note_t n;
        taken = i_instr_valid && !i_rst;
        #1;
        if (taken && q.size() == 0)
            check(64'h1, 64'h0);
        else if (taken)
        begin
            n = q.pop_front();
            check(64'({o_file_wr.addr, o_file_wr.data, o_file_wr.en} & {21{o_file_wr.en}}),
                  64'(n.wr));
            check(64'(o_state), 64'(n.st));
            check(64'(o_pc), 64'(n.pc));
            check(64'({o_indirect_pointer_reg[2], o_indirect_pointer_reg[1],
                       o_indirect_pointer_reg[0]}), 64'(n.ptrs));
            check(64'(o_discard), 64'(n.disc));
            check(64'(o_illegal), 64'(n.ill));
        end
        else
            check(64'({o_file_wr.en, o_discard}), 64'h0);
    end

    // watchdog: far beyond the ~700 cycles the run needs
    initial
    begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // main sequence: reset, a directed skip over a branch, random mix
    // ------------------------------------------------------------
    initial
    begin
        i_rst = 1'b1;
        i_instr_valid = 1'b0;
        i_instr = 16'h0000;
        i_bank_select_reg = 4'h0;
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'h00;
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        // skip taken over a branch: two no-op cycles in all
        issue({cpu_dec_pkg::OP6_DEC_SKIP_Z, 2'b11, 8'h10}, 4'h2, 8'h01, 1'b1);
        issue({cpu_dec_pkg::OP8_BRANCH, 8'h5a}, 4'h2, 8'h00, 1'b0);
        issue({cpu_dec_pkg::OP4_SECOND, 12'h3c1}, 4'h2, 8'h00, 1'b0);
        for (int i = 0; i < 500; i++)
        begin
            rnd = load_pointer_literal_next(rnd);
            case (rnd[3:0] % 4'hb)
                4'h7: issue({cpu_dec_pkg::OP8_OR_LIT, rnd[15:8]}, rnd[7:4], 8'h00, 1'b0);
                4'h8:
                begin
                    issue({cpu_dec_pkg::OP8_BRANCH, rnd[15:8]}, rnd[7:4], 8'h00, 1'b0);
                    issue({cpu_dec_pkg::OP4_SECOND, rnd[27:16]}, rnd[7:4], 8'h00, 1'b0);
                end
                4'h9:
                begin
                    issue({cpu_dec_pkg::OP10_LOAD_PTR, rnd[9:8], rnd[15:12]},
                          rnd[7:4], 8'h00, 1'b0);
                    issue({cpu_dec_pkg::OP8_PTR_SECOND, rnd[23:16]}, rnd[7:4], 8'h00, 1'b0);
                end
                4'ha: issue({8'h0d, rnd[15:8]}, rnd[7:4], 8'h00, 1'b0);
                default: issue({ops6[rnd[3:0] % 4'hb], rnd[15:6]}, rnd[7:4],
                               rnd[20] ? pokes[rnd[22:21]] : rnd[31:24], 1'b1);
            endcase
            if (rnd[23] && rnd[24])
            begin
                @(posedge i_clk);
                i_instr_valid <= 1'b0;
            end
        end
        @(posedge i_clk);
        i_instr_valid <= 1'b0;
        repeat (4) @(posedge i_clk);
        give_verdict();
    end
endmodule

// ===== design/cpu_dec_alu.sv
// result unit: increment, decrement, or and move with flag results
module cpu_dec_alu (
    // operands
    input wire logic [1:0] i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_acc,
    // result
    output logic [7:0] o_res,
    output logic [4:0] o_flags
);
    logic [8:0] sum; // nine bits to keep carry
    logic [4:0] nib; // digit carry tap
    logic [7:0] rhs; // addend
    // ----------------------------------------------------------
    // combinational result, op 0 inc 1 dec 2 or 3 move
    // ----------------------------------------------------------
    always_comb
    begin
        rhs = (i_op == 2'h1) ? 8'hff : 8'h01;
        sum = {1'b0, i_a} + {1'b0, rhs};
        nib = {1'b0, i_a[3:0]} + {1'b0, rhs[3:0]};
        case (i_op)
            2'h0, 2'h1: o_res = sum[7:0];
            2'h2: o_res = i_a | i_acc;
            default: o_res = i_a;
        endcase
        o_flags[cpu_dec_pkg::FLAG_C] = sum[8];
        o_flags[cpu_dec_pkg::FLAG_DC] = nib[4];
        o_flags[cpu_dec_pkg::FLAG_Z] = (o_res == 8'h00);
        o_flags[cpu_dec_pkg::FLAG_N] = o_res[7];
        // overflow: same-sign operands giving other sign
        o_flags[cpu_dec_pkg::FLAG_OV] = (i_a[7] == rhs[7]) && (sum[7] != i_a[7]);
    end
endmodule

// ===== design/cpu_dec_core.sv
// instruction executor for the inc/dec-skip, branch, or, pointer and move group
// Notes on behaviour
// - dec skip-if-zero, flags untouched
// - dec skip-if-nonzero on nonzero result
// - dest bit picks acc or file
// - access bit zero uses fixed bank
// - skip costs one or two cycles
// - skipped word becomes write-free no-op
// - branch literal loads pc bits 20:1
// - branch takes two cycles, second idle
// - branch two words, low then high
// - or literal into acc, n z
// - or file reg, routed, n z
// - pointer load high then low byte
module cpu_dec_core (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // instruction stream, one word per instruction cycle
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    // file register read data for the current address
    input wire logic [7:0] i_file_rdata,
    // bank select register from the register file
    input wire logic [3:0] i_bank_select_reg,
    // data address for the file read
    output logic [11:0] o_file_raddr,
    // file write port
    output cpu_dec_pkg::file_wr_t o_file_wr,
    // architectural state
    output cpu_dec_pkg::core_state_t o_state,
    output logic [20:0] o_pc,
    output logic [11:0] o_indirect_pointer_reg [cpu_dec_pkg::NUM_PTRS],
    // status
    output logic o_discard,
    output logic o_illegal
);
    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef enum {ST_EXEC, ST_SKIP, ST_SKIP2, ST_BR_HI, ST_PTR_LO} phase_t;
    phase_t phase_ff; // what the next word means
    phase_t nxt_phase;
    logic [7:0] acc_ff; // working register
    logic [4:0] flags_ff; // status flags
    logic [20:0] pc_ff; // program counter, byte address
    logic [7:0] lit_lo_ff; // branch low literal held for word two
    logic [1:0] ptr_sel_ff; // pointer chosen in word one
    logic [11:0] ptr_ff [cpu_dec_pkg::NUM_PTRS]; // indirect pointers
    cpu_dec_pkg::file_wr_t wr_ff; // registered write
    logic discard_ff; // this cycle was thrown away
    logic illegal_ff; // word not of this group
    // decode
    logic [5:0] op6;
    logic is_dz, is_dnz, is_inc, is_iz, is_inz, is_orf, is_mov, is_orl, is_br, is_lp;
    logic file_op; // read-modify-write class
    logic [1:0] alu_op;
    logic [7:0] res;
    logic [4:0] alu_flags;
    logic skip_taken;
    logic second_word; // this word opens a two-word form
    // ----------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------
    // branch and pointer load each drag a tail word behind them
    function automatic logic opens_pair(input logic [15:0] w);
        return (w[15:8] == cpu_dec_pkg::OP8_BRANCH) || (w[15:6] == cpu_dec_pkg::OP10_LOAD_PTR);
    endfunction
    // bank choice for an 8-bit file operand
    function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [3:0] bank_select_reg);
        logic [3:0] bank;
        bank = bank_select_reg;
        if (!w[cpu_dec_pkg::BIT_ACCESS])
            bank = (w[7:0] < cpu_dec_pkg::ACCESS_SPLIT) ? cpu_dec_pkg::ACCESS_BANK
                                                         : cpu_dec_pkg::ACCESS_HIGH_BANK;
        return {bank, w[7:0]};
    endfunction
    assign op6 = i_instr[15:10];
    assign is_dz = (op6 == cpu_dec_pkg::OP6_DEC_SKIP_Z);
    assign is_dnz = (op6 == cpu_dec_pkg::OP6_DEC_SKIP_NZ);
    assign is_inc = (op6 == cpu_dec_pkg::OP6_INC_FILE);
    assign is_iz = (op6 == cpu_dec_pkg::OP6_INC_SKIP_Z);
    assign is_inz = (op6 == cpu_dec_pkg::OP6_INC_SKIP_NZ);
    assign is_orf = (op6 == cpu_dec_pkg::OP6_OR_FILE);
    assign is_mov = (op6 == cpu_dec_pkg::OP6_MOVE_FILE);
    assign is_orl = (i_instr[15:8] == cpu_dec_pkg::OP8_OR_LIT);
    assign is_br = (i_instr[15:8] == cpu_dec_pkg::OP8_BRANCH);
    assign is_lp = (i_instr[15:6] == cpu_dec_pkg::OP10_LOAD_PTR);
    assign file_op = is_dz | is_dnz | is_inc | is_iz | is_inz | is_orf | is_mov;
    assign o_file_raddr = file_addr(i_instr, i_bank_select_reg);
    assign second_word = opens_pair(i_instr);
    // ----------------------------------------------------------
    // result unit
    // ----------------------------------------------------------
    always_comb
    begin
        if (is_dz || is_dnz)
            alu_op = 2'h1;
        else if (is_orf || is_orl)
            alu_op = 2'h2;
        else if (is_mov)
            alu_op = 2'h3;
        else
            alu_op = 2'h0;
    end
    cpu_dec_alu cpu_dec_alu_inst (
        .i_op(alu_op),
        .i_a(is_orl ? i_instr[7:0] : i_file_rdata),
        .i_acc(acc_ff),
        .o_res(res),
        .o_flags(alu_flags)
    );
    assign skip_taken = ((is_dz | is_iz) & (res == 8'h00))
                      | ((is_dnz | is_inz) & (res != 8'h00));
    // ----------------------------------------------------------
    // phase sequencing
    // ----------------------------------------------------------
    always_comb
    begin
        nxt_phase = phase_ff;
        if (i_instr_valid)
        begin
            case (phase_ff)
                ST_EXEC:
                begin
                    if (skip_taken)
                        nxt_phase = ST_SKIP;
                    else if (is_br)
                        nxt_phase = ST_BR_HI;
                    else if (is_lp)
                        nxt_phase = ST_PTR_LO;
                end
                // two-word victim costs one more cycle
                ST_SKIP: nxt_phase = second_word ? ST_SKIP2 : ST_EXEC;
                ST_SKIP2: nxt_phase = ST_EXEC;
                ST_BR_HI: nxt_phase = ST_EXEC;
                ST_PTR_LO: nxt_phase = ST_EXEC;
                default: nxt_phase = ST_EXEC;
            endcase
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            phase_ff <= ST_EXEC;
        else
            phase_ff <= nxt_phase;
    end
    // ----------------------------------------------------------
    // working register and flags
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            acc_ff <= cpu_dec_pkg::RESET_BYTE;
            flags_ff <= 5'h00;
        end
        else if (i_instr_valid && phase_ff == ST_EXEC)
        begin
            if (is_orl)
                acc_ff <= res;
            else if (file_op && !i_instr[cpu_dec_pkg::BIT_DEST])
                acc_ff <= res;
            // or and move set n and z only
            if (is_orl || is_orf || is_mov)
            begin
                flags_ff[cpu_dec_pkg::FLAG_N] <= alu_flags[cpu_dec_pkg::FLAG_N];
                flags_ff[cpu_dec_pkg::FLAG_Z] <= alu_flags[cpu_dec_pkg::FLAG_Z];
            end
            else if (is_inc)
                flags_ff <= alu_flags;
            // skip forms leave flags as they were
        end
    end
    // ----------------------------------------------------------
    // file write port, registered so the write lands after the read
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            wr_ff <= '0;
        else
        begin
            wr_ff.addr <= o_file_raddr;
            wr_ff.data <= res;
            // dest one writes back to file
            wr_ff.en <= i_instr_valid && phase_ff == ST_EXEC && file_op
                        && i_instr[cpu_dec_pkg::BIT_DEST];
        end
    end
    // ----------------------------------------------------------
    // program counter and branch literal
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pc_ff <= cpu_dec_pkg::RESET_PC;
            lit_lo_ff <= cpu_dec_pkg::RESET_BYTE;
        end
        else if (i_instr_valid)
        begin
            if (phase_ff == ST_EXEC && is_br)
                lit_lo_ff <= i_instr[7:0];
            if (phase_ff == ST_BR_HI)
                pc_ff <= {i_instr[11:0], lit_lo_ff, 1'b0};
            else
                pc_ff <= pc_ff + 21'h000002;
        end
    end
    // ----------------------------------------------------------
    // indirect pointers
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ptr_sel_ff <= 2'h0;
            for (int i = 0; i < cpu_dec_pkg::NUM_PTRS; i++)
                ptr_ff[i] <= 12'h000;
        end
        else if (i_instr_valid)
        begin
            if (phase_ff == ST_EXEC && is_lp)
            begin
                // select three names no pointer; keep it so its tail is dropped too
                ptr_sel_ff <= i_instr[5:4];
                if (i_instr[5:4] != 2'h3)
                    ptr_ff[i_instr[5:4]][11:8] <= i_instr[3:0];
            end
            if (phase_ff == ST_PTR_LO && ptr_sel_ff != 2'h3)
                ptr_ff[ptr_sel_ff][7:0] <= i_instr[7:0];
        end
    end
    // ----------------------------------------------------------
    // status outputs
    // ----------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            discard_ff <= 1'b0;
            illegal_ff <= 1'b0;
        end
        else
        begin
            // skipped and branch-second cycles are idle
            discard_ff <= i_instr_valid && (phase_ff == ST_SKIP || phase_ff == ST_SKIP2
                                            || phase_ff == ST_BR_HI);
            // words outside this group are flagged, not executed
            illegal_ff <= i_instr_valid && phase_ff == ST_EXEC && !file_op && !is_orl
                          && !is_br && !is_lp;
        end
    end
    assign o_file_wr = wr_ff;
    assign o_state = '{flags: flags_ff, acc: acc_ff};
    assign o_pc = pc_ff;
    assign o_indirect_pointer_reg = ptr_ff;
    assign o_discard = discard_ff;
    assign o_illegal = illegal_ff;
    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    sequence s_dec_zero;
        i_instr_valid && phase_ff == ST_EXEC && is_dz && res == 8'h00;
    endsequence
    // a word taken in either skip phase is the discarded victim
    sequence s_victim;
        i_instr_valid && (phase_ff == ST_SKIP || phase_ff == ST_SKIP2);
    endsequence
    sequence s_next_idle;
        ##1 discard_ff && !wr_ff.en && $stable(acc_ff);
    endsequence
    property p_dz_skip;
        @(posedge i_clk) disable iff (i_rst) s_dec_zero |=> phase_ff == ST_SKIP;
    endproperty
    a_dz_skip: assert property (p_dz_skip) else $error("zero decrement did not skip");
    property p_victim;
        @(posedge i_clk) disable iff (i_rst) s_victim |-> s_next_idle;
    endproperty
    a_victim: assert property (p_victim) else $error("skipped word was not idle");
    property p_dz_flags;
        @(posedge i_clk) disable iff (i_rst) s_dec_zero |=> $stable(flags_ff);
    endproperty
    a_dz_flags: assert property (p_dz_flags) else $error("skip changed flags");
    property p_dnz;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_EXEC && is_dnz && res != 8'h00) |=> phase_ff == ST_SKIP;
    endproperty
    a_dnz: assert property (p_dnz) else $error("nonzero decrement did not skip");
    property p_dest_acc;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_EXEC && file_op && !i_instr[cpu_dec_pkg::BIT_DEST])
            |=> acc_ff == $past(res) && !wr_ff.en;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("dest zero misrouted");
    property p_access;
        @(posedge i_clk) disable iff (i_rst)
            (!i_instr[cpu_dec_pkg::BIT_ACCESS] && i_instr[7:0] < cpu_dec_pkg::ACCESS_SPLIT)
            |-> o_file_raddr[11:8] == cpu_dec_pkg::ACCESS_BANK;
    endproperty
    a_access: assert property (p_access) else $error("access bank not used");
    property p_skip2;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_SKIP && second_word) |=> phase_ff == ST_SKIP2;
    endproperty
    a_skip2: assert property (p_skip2) else $error("two-word skip too short");
    property p_branch;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_BR_HI)
            |=> pc_ff == {$past(i_instr[11:0]), $past(lit_lo_ff), 1'b0} && discard_ff;
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");
    property p_or_lit;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_EXEC && is_orl)
            |=> acc_ff == ($past(acc_ff) | $past(i_instr[7:0]));
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("literal or wrong");
    property p_br_lo;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_EXEC && is_br)
            |=> phase_ff == ST_BR_HI && lit_lo_ff == $past(i_instr[7:0]);
    endproperty
    a_br_lo: assert property (p_br_lo) else $error("branch low literal lost");
    property p_ptr_lo;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_PTR_LO && ptr_sel_ff != 2'h3)
            |=> ptr_ff[ptr_sel_ff][7:0] == $past(i_instr[7:0]);
    endproperty
    a_ptr_lo: assert property (p_ptr_lo) else $error("pointer low byte wrong");
    property p_inc_flags;
        @(posedge i_clk) disable iff (i_rst)
            (i_instr_valid && phase_ff == ST_EXEC && is_inc)
            |=> flags_ff[cpu_dec_pkg::FLAG_C] == ($past(i_file_rdata) == 8'hff)
                && flags_ff[cpu_dec_pkg::FLAG_Z] == ($past(i_file_rdata) == 8'hff);
    endproperty
    a_inc_flags: assert property (p_inc_flags) else $error("increment flags wrong");
endmodule

// ===== design/cpu_dec_pkg.sv
// package: opcodes, field layout, flag positions and reset values for the decoder
package cpu_dec_pkg;
    // --------------------------------------------------------------
    // opcode prefixes
    // --------------------------------------------------------------
    localparam logic [5:0] OP6_DEC_SKIP_Z = 6'h0b;    // 0010 11
    localparam logic [5:0] OP6_DEC_SKIP_NZ = 6'h13;   // 0100 11
    localparam logic [5:0] OP6_INC_FILE = 6'h0a;      // 0010 10
    localparam logic [5:0] OP6_INC_SKIP_Z = 6'h0f;    // 0011 11
    localparam logic [5:0] OP6_INC_SKIP_NZ = 6'h12;   // 0100 10
    localparam logic [5:0] OP6_OR_FILE = 6'h04;       // 0001 00
    localparam logic [5:0] OP6_MOVE_FILE = 6'h14;     // 0101 00
    localparam logic [7:0] OP8_OR_LIT = 8'h09;        // 0000 1001
    localparam logic [7:0] OP8_BRANCH = 8'hef;        // 1110 1111
    localparam logic [9:0] OP10_LOAD_PTR = 10'h3b8;   // 1110 1110 00
    localparam logic [3:0] OP4_SECOND = 4'hf;         // second word prefix
    localparam logic [7:0] OP8_PTR_SECOND = 8'hf0;    // pointer-load second word
    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int BIT_DEST = 9;
    localparam int BIT_ACCESS = 8;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam logic [3:0] ACCESS_BANK = 4'h0;        // fixed bank for a=0
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;      // addresses below 8'h60 in bank 0, rest in bank f
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [20:0] RESET_PC = 21'h000000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int NUM_PTRS = 3;
    // --------------------------------------------------------------
    // carrier types
    // --------------------------------------------------------------
    typedef struct packed {
        logic [11:0] addr;  // full data address
        logic [7:0] data;   // byte written
        logic en;           // write strobe
    } file_wr_t;
    typedef struct packed {
        logic [4:0] flags;  // n ov z dc c
        logic [7:0] acc;    // working register
    } core_state_t;
endpackage
